//--- design/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
   parameter int W = 11
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // control
   input  wire logic         tick,
   input  wire logic         clear,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   // status
   output logic              expired
);

   logic [W-1:0] count_q;

   // counts ticks while running, sticks at expiry until cleared;
   // expiry waits one tick past the limit so a partial first tick never shortens the interval
   always_ff @(posedge clk)
   begin
      if (srst || clear)
      begin
         count_q <= '0;
         expired <= 1'b0;
      end
      else if (run && tick && !expired)
      begin
         count_q <= count_q + W'(1);
         if (count_q >= limit)
         begin
            expired <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

//--- design/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // first stage is read only by the second
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule
`default_nettype wire

//--- design/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // timer widths, counts are in ticks of one millisecond
   localparam int COUNT_W = 11;
   localparam int WD_PERIOD_0_MS = 25;
   localparam int WD_PERIOD_1_MS = 200;
   localparam int WD_PERIOD_2_MS = 1400;
   localparam int HOLD_TIME_0_MS = 50;
   localparam int HOLD_TIME_1_MS = 200;
   localparam int HOLD_TIME_2_MS = 400;
   localparam int HOLD_TIME_3_MS = 800;

   // watchdog period select codes
   localparam logic [1:0] WD_SEL_25MS = 2'h0;
   localparam logic [1:0] WD_SEL_200MS = 2'h1;
   localparam logic [1:0] WD_SEL_1400MS = 2'h2;
   localparam logic [1:0] WD_SEL_OFF = 2'h3;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATE = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;

   // control register fields
   localparam int CTRL_W = 4;
   localparam int CTRL_WD_LSB = 0;
   localparam int CTRL_HOLD_LSB = 2;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // state register and event bits
   localparam int STATE_RESET_BIT = 0;
   localparam int STATE_ALARM_BIT = 1;
   localparam int STATE_PRIMARY_LOW_BIT = 2;
   localparam int STATE_SECONDARY_FAIL_BIT = 3;
   localparam int EVT_W = 4;
   localparam int EVT_WD_EXPIRED = 0;
   localparam int EVT_RESTART = 1;
   localparam int EVT_PRIMARY_LOW = 2;
   localparam int EVT_SECONDARY_FAIL = 3;
   localparam logic [3:0] EVT_RESET = 4'h0;

   typedef enum logic [2:0] {
      RS_IDLE    = 3'h1,
      RS_STARTED = 3'h2,
      RS_ARMED   = 3'h4
   } restart_state_t;

endpackage
`default_nettype wire

//--- design/supervisor_reset_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog #(
   parameter int TICK_CYCLES      = supervisor_pkg::TICK_CYCLES,
   parameter bit RESET_PUSH_PULL  = 1'b1
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // interrupt
   output logic             irq,
   // two-wire bus, observed only
   input  wire logic        sda_in,
   input  wire logic        scl_in,
   // comparators
   input  wire logic        primary_low_in,
   input  wire logic        secondary_monitor_in,
   // nonvolatile control store
   input  wire logic [3:0]  nv_ctrl_in,
   output logic [3:0]       nv_ctrl_out,
   output logic             nv_store_out,
   // reset output, both variants
   output logic             reset_high_out,
   output logic             reset_low_out,
   output logic             reset_low_oe_n,
   // open-drain supervisory outputs
   output logic             watchdog_alarm_out,
   output logic             watchdog_alarm_oe_n,
   output logic             secondary_fail_out,
   output logic             secondary_fail_oe_n
);

   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int CW = supervisor_pkg::COUNT_W;

   // synchronised pins
   logic                        sda_s;
   logic                        scl_s;
   logic                        primary_low_s;
   logic                        secondary_ok_s;
   logic                        sda_prev_q;
   logic                        scl_prev_q;
   // time base
   logic [TW-1:0]               tick_cnt_q;
   logic                        tick_q;
   // control
   logic [3:0]                  ctrl_q;
   logic                        ctrl_loaded_q;
   logic [1:0]                  wd_sel;
   logic [1:0]                  hold_sel;
   logic [CW-1:0]               wd_limit;
   logic [CW-1:0]               hold_limit;
   // restart detection
   supervisor_pkg::restart_state_t rs_q;
   logic                        restart_q;
   logic                        start_cond;
   logic                        stop_cond;
   logic                        scl_fall;
   // timers
   logic                        wd_expired;
   logic                        wd_clear;
   logic                        hold_expired;
   logic                        hold_clear;
   logic                        reset_active_q;
   logic                        alarm_q;
   logic                        secondary_fail_q;
   logic                        primary_low_q;
   // interrupts and bus
   logic [3:0]                  evt_status_q;
   logic [3:0]                  evt_enable_q;
   logic [3:0]                  evt_set;
   logic [3:0]                  evt_clr;
   logic                        bus_access;
   logic                        bus_commit;
   logic                        addr_ok;
   logic [31:0]                 rdata;

   level_sync #(.W (4)) u_pin_sync (
      .clk      (clk),
      .srst     (srst),
      .async_in ({sda_in, scl_in, primary_low_in, secondary_monitor_in}),
      .sync_out ({sda_s, scl_s, primary_low_s, secondary_ok_s})
   );

   // one-millisecond tick from a free-running prescaler
   always_ff @(posedge clk)
   begin
      tick_q     <= !srst && tick_cnt_q == TW'(TICK_CYCLES - 1);
      tick_cnt_q <= (srst || tick_cnt_q == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_q + TW'(1);
   end

   // bus edge detection, independent of any addressing
   always_ff @(posedge clk)
   begin
      sda_prev_q <= srst ? 1'b1 : sda_s;
      scl_prev_q <= srst ? 1'b1 : scl_s;
   end

   assign start_cond = sda_prev_q && !sda_s && scl_s && scl_prev_q;
   assign stop_cond  = !sda_prev_q && sda_s && scl_s && scl_prev_q;
   assign scl_fall   = scl_prev_q && !scl_s;

   // start, clock fall, then stop gives one restart pulse
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rs_q      <= supervisor_pkg::RS_IDLE;
         restart_q <= 1'b0;
      end
      else
      begin
         restart_q <= 1'b0;
         case (rs_q)
            supervisor_pkg::RS_IDLE:
               if (start_cond)
                  rs_q <= supervisor_pkg::RS_STARTED;
            supervisor_pkg::RS_STARTED:
               if (stop_cond)
                  rs_q <= supervisor_pkg::RS_IDLE;
               else if (scl_fall)
                  rs_q <= supervisor_pkg::RS_ARMED;
            supervisor_pkg::RS_ARMED:
               if (stop_cond)
               begin
                  rs_q      <= supervisor_pkg::RS_IDLE;
                  restart_q <= 1'b1;
               end
               else if (start_cond)
                  rs_q <= supervisor_pkg::RS_STARTED;
            default:
               rs_q <= supervisor_pkg::RS_IDLE;
         endcase
      end
   end

   // control register, reloaded from the nonvolatile store after reset
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_q        <= supervisor_pkg::CTRL_RESET;
         ctrl_loaded_q <= 1'b0;
         nv_ctrl_out   <= supervisor_pkg::CTRL_RESET;
         nv_store_out  <= 1'b0;
      end
      else
      begin
         nv_store_out <= 1'b0;
         if (!ctrl_loaded_q)
         begin
            ctrl_q        <= nv_ctrl_in;
            nv_ctrl_out   <= nv_ctrl_in;
            ctrl_loaded_q <= 1'b1;
         end
         else if (bus_commit && pwrite && paddr == supervisor_pkg::ADDR_CTRL)
         begin
            ctrl_q       <= pwdata[3:0];
            nv_ctrl_out  <= pwdata[3:0];
            nv_store_out <= 1'b1;
         end
      end
   end

   assign wd_sel   = ctrl_q[supervisor_pkg::CTRL_WD_LSB +: 2];
   assign hold_sel = ctrl_q[supervisor_pkg::CTRL_HOLD_LSB +: 2];

   // period and hold time in ticks
   always_comb
   begin
      case (wd_sel)
         2'h0:    wd_limit = CW'(supervisor_pkg::WD_PERIOD_0_MS);
         2'h1:    wd_limit = CW'(supervisor_pkg::WD_PERIOD_1_MS);
         2'h2:    wd_limit = CW'(supervisor_pkg::WD_PERIOD_2_MS);
         default: wd_limit = CW'(supervisor_pkg::WD_PERIOD_2_MS);
      endcase
      case (hold_sel)
         2'h0:    hold_limit = CW'(supervisor_pkg::HOLD_TIME_0_MS);
         2'h1:    hold_limit = CW'(supervisor_pkg::HOLD_TIME_1_MS);
         2'h2:    hold_limit = CW'(supervisor_pkg::HOLD_TIME_2_MS);
         default: hold_limit = CW'(supervisor_pkg::HOLD_TIME_3_MS);
      endcase
   end

   // a restart or the off setting empties the watchdog count
   assign wd_clear = restart_q || wd_sel == supervisor_pkg::WD_SEL_OFF || !ctrl_loaded_q;

   interval_timer #(.W (CW)) u_wd_timer (
      .clk     (clk),
      .srst    (srst),
      .tick    (tick_q),
      .clear   (wd_clear),
      .run     (1'b1),
      .limit   (wd_limit),
      .expired (wd_expired)
   );

   // hold time restarts whenever the supply dips
   assign hold_clear = primary_low_s || !ctrl_loaded_q;

   interval_timer #(.W (CW)) u_hold_timer (
      .clk     (clk),
      .srst    (srst),
      .tick    (tick_q),
      .clear   (hold_clear),
      .run     (!primary_low_s),
      .limit   (hold_limit),
      .expired (hold_expired)
   );

   // supervisory state and pins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reset_active_q      <= 1'b1;
         alarm_q             <= 1'b0;
         secondary_fail_q    <= 1'b1; // matches the synchroniser's reset level, no false fail event
         primary_low_q       <= 1'b0;
         reset_high_out      <= RESET_PUSH_PULL;
         reset_low_out       <= 1'b0;
         reset_low_oe_n      <= RESET_PUSH_PULL;
         watchdog_alarm_out  <= 1'b1;
         watchdog_alarm_oe_n <= 1'b1;
         secondary_fail_out  <= 1'b0;
         secondary_fail_oe_n <= 1'b0;
      end
      else
      begin
         reset_active_q      <= primary_low_s || !hold_expired;
         alarm_q             <= wd_expired;
         secondary_fail_q    <= !secondary_ok_s;
         primary_low_q       <= primary_low_s;
         reset_high_out      <= RESET_PUSH_PULL && reset_active_q;
         reset_low_out       <= 1'b0;
         reset_low_oe_n      <= RESET_PUSH_PULL || !reset_active_q;
         watchdog_alarm_out  <= !alarm_q;
         watchdog_alarm_oe_n <= !alarm_q;
         secondary_fail_out  <= secondary_ok_s;
         secondary_fail_oe_n <= secondary_ok_s;
      end
   end

   // event sources for the interrupt status
   always_comb
   begin
      evt_set = supervisor_pkg::EVT_RESET;
      evt_set[supervisor_pkg::EVT_WD_EXPIRED]     = wd_expired && !alarm_q;
      evt_set[supervisor_pkg::EVT_RESTART]        = restart_q;
      evt_set[supervisor_pkg::EVT_PRIMARY_LOW]    = primary_low_s && !primary_low_q;
      evt_set[supervisor_pkg::EVT_SECONDARY_FAIL] = !secondary_ok_s && !secondary_fail_q;
      evt_clr = (bus_commit && pwrite && paddr == supervisor_pkg::ADDR_IRQ_CLEAR) ? pwdata[3:0]
                                                                                  : supervisor_pkg::EVT_RESET;
   end

   // sticky status, a new event wins over a clear
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         evt_status_q <= supervisor_pkg::EVT_RESET;
         evt_enable_q <= supervisor_pkg::EVT_RESET;
         irq          <= 1'b0;
      end
      else
      begin
         evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
         if (bus_commit && pwrite && paddr == supervisor_pkg::ADDR_IRQ_ENABLE)
            evt_enable_q <= pwdata[3:0];
         irq <= |(evt_status_q & evt_enable_q);
      end
   end

   // apb: one wait state, answer registered
   assign bus_access = psel && penable && !pready;
   assign bus_commit = psel && penable && pready;

   always_comb
   begin
      rdata   = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         supervisor_pkg::ADDR_CTRL:       rdata[3:0] = ctrl_q;
         supervisor_pkg::ADDR_STATE:
         begin
            rdata[supervisor_pkg::STATE_RESET_BIT]          = reset_active_q;
            rdata[supervisor_pkg::STATE_ALARM_BIT]          = alarm_q;
            rdata[supervisor_pkg::STATE_PRIMARY_LOW_BIT]    = primary_low_q;
            rdata[supervisor_pkg::STATE_SECONDARY_FAIL_BIT] = secondary_fail_q;
         end
         supervisor_pkg::ADDR_IRQ_STATUS: rdata[3:0] = evt_status_q;
         supervisor_pkg::ADDR_IRQ_CLEAR:  rdata[3:0] = 4'h0;
         supervisor_pkg::ADDR_IRQ_ENABLE: rdata[3:0] = evt_enable_q;
         default:                         addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= bus_access;
         prdata  <= (bus_access && !pwrite) ? rdata : 32'h0000_0000;
         pslverr <= bus_access && (!addr_ok || (pwrite && paddr == supervisor_pkg::ADDR_STATE)
                                            || (pwrite && paddr == supervisor_pkg::ADDR_IRQ_STATUS));
      end
   end

endmodule
`default_nettype wire

//--- testbench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   // clock
   input  wire logic clk,
   // two-wire bus lines, high through the pull-ups when idle
   output logic      sda,
   output logic      scl
);
   // each level stands five cycles, above the three the detector needs
   localparam int HOLD = 5;

   initial
   begin
      sda = 1'b1;
      scl = 1'b1;
   end

   task automatic put(input logic d, input logic c);
      sda <= d;
      scl <= c;
      repeat (HOLD) @(posedge clk);
   endtask

   // restart frame with no address byte; keep_scl leaves out the clock fall
   task automatic restart(input bit keep_scl);
      put(1'b0, 1'b1);
      put(1'b0, keep_scl);
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
   endtask
endmodule
`default_nettype wire

//--- testbench/supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_props #(
   parameter int TICK_CYCLES     = 10,
   parameter bit RESET_PUSH_PULL = 1'b1
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // comparators
   input wire logic        primary_low_in,
   input wire logic        secondary_monitor_in,
   // nonvolatile store
   input wire logic [3:0]  nv_ctrl_out,
   input wire logic        nv_store_out,
   // supervisory outputs
   input wire logic        reset_high_out,
   input wire logic        reset_low_out,
   input wire logic        reset_low_oe_n,
   input wire logic        watchdog_alarm_out,
   input wire logic        watchdog_alarm_oe_n,
   input wire logic        secondary_fail_out,
   input wire logic        secondary_fail_oe_n
);
   localparam int HOLD_MIN = supervisor_pkg::HOLD_TIME_0_MS * TICK_CYCLES;
   logic        rst_on;
   logic [15:0] ok_cnt_q;

   // reset asserted, whichever variant is built
   assign rst_on = RESET_PUSH_PULL ? reset_high_out : !reset_low_oe_n;

   // cycles since the supply pin last reported low
   always_ff @(posedge clk)
   begin
      if (srst || primary_low_in)
         ok_cnt_q <= '0;
      else if (ok_cnt_q != 16'hffff)
         ok_cnt_q <= ok_cnt_q + 16'h0001;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_ctrl_write;
      psel && penable && pready && pwrite && paddr == supervisor_pkg::ADDR_CTRL;
   endsequence
   sequence s_store;
      nv_store_out && nv_ctrl_out == $past(pwdata[3:0]) ##1 !nv_store_out;
   endsequence

   chk_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_ready_wait: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("pready without a waited access");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero when idle");
   chk_store_pulse: assert property (s_ctrl_write |=> s_store)
      else $error("store pulse wrong after control write");
   chk_fail_high: assert property (secondary_monitor_in [*7] |-> secondary_fail_out)
      else $error("fail output low with monitor above");
   chk_fail_low: assert property (!secondary_monitor_in [*7] |-> !secondary_fail_out)
      else $error("fail output high with monitor below");
   chk_fail_pins: assert property (secondary_fail_oe_n == secondary_fail_out)
      else $error("fail enable and level disagree");
   chk_reset_low: assert property (primary_low_in [*8] |-> rst_on)
      else $error("reset not asserted on low supply");
   chk_reset_hold: assert property ($fell(rst_on) |-> ok_cnt_q >= HOLD_MIN)
      else $error("reset released before hold time");
   chk_reset_variant: assert property (!reset_low_out && (RESET_PUSH_PULL ? reset_low_oe_n : !reset_high_out))
      else $error("unused reset variant active");
   chk_alarm_pins: assert property (watchdog_alarm_oe_n == watchdog_alarm_out)
      else $error("alarm enable and level disagree");
endmodule

bind supervisor_reset_watchdog supervisor_props #(.TICK_CYCLES(TICK_CYCLES), .RESET_PUSH_PULL(RESET_PUSH_PULL)) u_props (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .primary_low_in(primary_low_in), .secondary_monitor_in(secondary_monitor_in),
   .nv_ctrl_out(nv_ctrl_out), .nv_store_out(nv_store_out), .reset_high_out(reset_high_out),
   .reset_low_out(reset_low_out), .reset_low_oe_n(reset_low_oe_n), .watchdog_alarm_out(watchdog_alarm_out),
   .watchdog_alarm_oe_n(watchdog_alarm_oe_n), .secondary_fail_out(secondary_fail_out),
   .secondary_fail_oe_n(secondary_fail_oe_n)
);
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int T = 10;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        primary_low_in = 1'b0;
   logic        secondary_monitor_in = 1'b1;
   logic [3:0]  nv_ctrl_in = 4'h3;
   wire logic   pready, pslverr, irq, sda, scl, nv_store_out;
   wire logic   reset_high_out, reset_low_oe_n, watchdog_alarm_out, secondary_fail_out;
   wire logic [31:0] prdata;
   wire logic [3:0]  nv_ctrl_out;
   logic [31:0] rd;
   logic        err;
   int          took;
   int          miscompares = 0;
   int          check_count = 0;

   always #50 clk = ~clk;

   host_bus_model hm (.clk(clk), .sda(sda), .scl(scl));

   supervisor_reset_watchdog #(.TICK_CYCLES(T), .RESET_PUSH_PULL(1'b1)) u_dut (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
      .sda_in(sda), .scl_in(scl), .primary_low_in(primary_low_in),
      .secondary_monitor_in(secondary_monitor_in), .nv_ctrl_in(nv_ctrl_in), .nv_ctrl_out(nv_ctrl_out),
      .nv_store_out(nv_store_out), .reset_high_out(reset_high_out), .reset_low_out(),
      .reset_low_oe_n(reset_low_oe_n), .watchdog_alarm_out(watchdog_alarm_out), .watchdog_alarm_oe_n(),
      .secondary_fail_out(secondary_fail_out), .secondary_fail_oe_n()
   );

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic timeout_stop();
      miscompares++;
      $display("unexpected at %0t: no answer in time", $time);
      report_and_stop();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   task automatic check_in(input int v, input int lo, input int hi);
      check(32'(v >= lo && v <= hi), 32'h0000_0001);
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return reset_high_out;
         1: return watchdog_alarm_out;
         2: return irq;
         default: return secondary_fail_out;
      endcase
   endfunction

   task automatic wait_for(input int w, input logic v, input int lim, output int n);
      n = 0;
      while (pick(w) !== v && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      if (pick(w) !== v)
         timeout_stop();
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (pready !== 1'b1)
         timeout_stop();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic test_power_up();
      check(32'(reset_low_oe_n), 32'h0000_0001);
      wait_for(0, 1'b0, 700, took);
      check_in(took, 50 * T, 50 * T + T + 10);
      apb(1'b0, supervisor_pkg::ADDR_CTRL, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0003);
      check(32'(watchdog_alarm_out), 32'h0000_0001);
      apb(1'b0, supervisor_pkg::ADDR_STATE, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      $display("power_up done");
   endtask

   task automatic test_watchdog();
      int per[3];
      per = '{supervisor_pkg::WD_PERIOD_0_MS, supervisor_pkg::WD_PERIOD_1_MS, supervisor_pkg::WD_PERIOD_2_MS};
      for (int s = 0; s < 4; s++)
      begin
         apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'(s), rd, err);
         hm.restart(1'b0);
         if (s == 3)
         begin
            repeat (supervisor_pkg::WD_PERIOD_2_MS * T + 100) @(posedge clk);
            check(32'(watchdog_alarm_out), 32'h0000_0001);
         end
         else
         begin
            wait_for(1, 1'b0, per[s] * T + 40, took);
            check_in(took, per[s] * T - 10, per[s] * T + T + 10);
            if (s == 0)
            begin
               hm.restart(1'b1);
               repeat (4) @(posedge clk);
               check(32'(watchdog_alarm_out), 32'h0000_0000);
            end
            hm.restart(1'b0);
            wait_for(1, 1'b1, 20, took);
         end
      end
      $display("watchdog done");
   endtask

   task automatic test_irq();
      apb(1'b1, supervisor_pkg::ADDR_IRQ_CLEAR, 32'h0000_000f, rd, err);
      apb(1'b1, supervisor_pkg::ADDR_IRQ_ENABLE, 32'h0000_0000, rd, err);
      hm.restart(1'b0);
      apb(1'b0, supervisor_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0002);
      check(32'(irq), 32'h0000_0000);
      apb(1'b1, supervisor_pkg::ADDR_IRQ_ENABLE, 32'h0000_0002, rd, err);
      wait_for(2, 1'b1, 5, took);
      apb(1'b1, supervisor_pkg::ADDR_IRQ_CLEAR, 32'h0000_0002, rd, err);
      wait_for(2, 1'b0, 5, took);
      apb(1'b0, supervisor_pkg::ADDR_IRQ_CLEAR, 32'h0000_0000, rd, err);
      check({rd[30:0], err}, 32'h0000_0000);
      apb(1'b1, supervisor_pkg::ADDR_STATE, 32'h0000_000f, rd, err);
      check(32'(err), 32'h0000_0001);
      apb(1'b0, 8'h14, 32'h0000_0000, rd, err);
      check({rd[30:0], err}, 32'h0000_0001);
      $display("irq done");
   endtask

   task automatic test_primary();
      int hold[4];
      hold = '{supervisor_pkg::HOLD_TIME_0_MS, supervisor_pkg::HOLD_TIME_1_MS,
               supervisor_pkg::HOLD_TIME_2_MS, supervisor_pkg::HOLD_TIME_3_MS};
      for (int h = 0; h < 4; h++)
      begin
         apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'(h * 4 + 3), rd, err);
         primary_low_in <= 1'b1;
         wait_for(0, 1'b1, 8, took);
         repeat (20) @(posedge clk);
         primary_low_in <= 1'b0;
         repeat (100) @(posedge clk);
         // a dip inside the hold must start the hold again
         primary_low_in <= 1'b1;
         repeat (10) @(posedge clk);
         primary_low_in <= 1'b0;
         wait_for(0, 1'b0, hold[h] * T + 40, took);
         check_in(took, hold[h] * T, hold[h] * T + T + 10);
      end
      $display("primary done");
   endtask

   task automatic test_secondary();
      secondary_monitor_in <= 1'b0;
      wait_for(3, 1'b0, 6, took);
      apb(1'b0, supervisor_pkg::ADDR_STATE, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0008);
      secondary_monitor_in <= 1'b1;
      wait_for(3, 1'b1, 6, took);
      $display("secondary done");
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      test_power_up();
      test_watchdog();
      test_irq();
      test_primary();
      test_secondary();
      report_and_stop();
   end
endmodule
`default_nettype wire
